// *** pkg/envelope_crypto_pkg.sv ***
// shared constants and types for the envelope counter-mode crypto datapath
package envelope_crypto_pkg;

    localparam int NCH       = 4;
    localparam int CH_W      = 2;
    localparam int NENT      = 16;
    localparam int ENT_W     = 4;
    localparam int EQ_W      = 64;
    localparam int CTL_W     = 8;
    localparam int BLK_W     = 128;
    localparam int LLID_W    = 16;
    localparam int TMR_W     = 16;
    localparam int FIFO_DEPTH = 16;

    // initialization vector layout, msb first
    localparam int IV_CHN_W  = 7;
    localparam int MAC_W     = 48;
    localparam int TIME_W    = 48;
    localparam int BIDX_W    = 24;

    // header quantum: control flag on lane 0 with this code in byte 0
    localparam logic [7:0] HDR_CODE = 8'h5c;

    // entity map: llids at or above the base are multicast
    localparam logic [LLID_W-1:0] MCAST_BASE = 16'h7f00;
    localparam int UNIT_LSB  = 3;
    localparam int UNIT_W    = 3;
    localparam int MCAST_W   = 3;

    // key lifetime timer counts in ticks of this length
    localparam int CLK_NS       = 100;
    localparam int KEY_TICK_NS  = 1000;
    localparam int KEY_TICK_CYC = (KEY_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_W       = 4;

    typedef struct packed {
        logic [EQ_W-1:0]  data;
        logic [CTL_W-1:0] ctrl;
    } eq_t;

    typedef struct packed {
        eq_t               eq;
        logic [CH_W-1:0]   ch;
        logic [LLID_W-1:0] llid;
        logic              enc;
    } tag_eq_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EVAL = 3'b010,
        ST_AES  = 3'b100
    } state_t;

endpackage

// *** src/envelope_aes_ctr_crypto.sv ***
// envelope counter-mode crypto datapath with its input fifo
`timescale 1ns/1ns
`default_nettype none

// input buffer; ready is registered so it can leave the block directly
module crypto_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    logic [AW:0]      wp_d;
    logic [AW:0]      rp_d;
    logic             ready_q;
    logic             push;
    logic             pop;

    assign push       = i_wr_valid && ready_q;
    assign pop        = i_rd_ready && o_rd_valid;
    assign wp_d       = push ? wp_q + 1'b1 : wp_q;
    assign rp_d       = pop ? rp_q + 1'b1 : rp_q;
    assign o_rd_valid = wp_q != rp_q;
    assign o_rd_data  = mem[rp_q[AW-1:0]];
    assign o_wr_ready = ready_q;

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            wp_q    <= '0;
            rp_q    <= '0;
            ready_q <= 1'b0;
        end else begin
            wp_q    <= wp_d;
            rp_q    <= rp_d;
            // full when pointers differ only in the wrap bit
            ready_q <= !((wp_d[AW] != rp_d[AW]) && (wp_d[AW-1:0] == rp_d[AW-1:0]));
        end
    end
endmodule // crypto_fifo

// Functional notes
// - iv built from channel index and header quantum, first cipher input block
// - header detection flags exactly the quanta that are envelope headers
// - each multicast llid maps to its own distinct entity index; the code uses only the low three llid bits, so llids eight apart share one
// - all unicast llids of one subscriber unit share one entity index
// - one countdown lifetime timer per entity; expired key is never used
// - timer expiry sets that entity's expired flag
// - central side: independent encryption activation instance per transmit channel
// - both sides: independent decryption activation instance per receive channel
// - subscriber side: independent encryption activation instance per transmit channel
// - ciphertext is cipher output of successive counters xor plaintext
// - counter values never repeat under one key
// - headers pass in clear; only payload is en- or decrypted
// - one key per payload; new key switches only at a header
// - 128-bit blocks, each covering two payload quanta
// - cipher output anded with mask zeroing control-character lanes
// - first counter equals iv, each next counter is previous plus one
// - odd final quantum uses upper 64 bits; lower 64 discarded
// - plaintext is cipher output of counters xor ciphertext
// - receiver iv and counters match those of the transmitter
// - cipher runs on counters as soon as their values are known; the code requests a block only when a payload quantum needs one
// - iv top bit is direction, next seven bits channel number
// - new iv computed at every observed envelope header
module envelope_aes_ctr_crypto (
    input  wire logic                                   i_core_clk,
    input  wire logic                                   i_rst_b,
    input  wire logic                                   i_dir_up,
    input  wire logic [envelope_crypto_pkg::MAC_W-1:0]  i_mac_addr,
    input  wire logic                                   i_in_valid,
    output logic                                        o_in_ready,
    input  wire envelope_crypto_pkg::tag_eq_t           i_in_eq,
    output logic                                        o_out_valid,
    input  wire logic                                   i_out_ready,
    output envelope_crypto_pkg::tag_eq_t                o_out_eq,
    output logic                                        o_out_fault,
    output logic                                        o_hdr_seen,
    output logic                                        o_aes_req,
    output logic [envelope_crypto_pkg::BLK_W-1:0]       o_aes_ctr,
    output logic [envelope_crypto_pkg::ENT_W-1:0]       o_aes_ent,
    output logic                                        o_aes_slot,
    input  wire logic                                   i_aes_ack,
    input  wire logic [envelope_crypto_pkg::BLK_W-1:0]  i_aes_block,
    input  wire logic [envelope_crypto_pkg::NENT-1:0]   i_key_load,
    input  wire logic [envelope_crypto_pkg::TMR_W-1:0]  i_key_interval,
    input  wire logic [envelope_crypto_pkg::NENT-1:0]   i_key_activate,
    output logic [envelope_crypto_pkg::NENT-1:0]        o_key_expired
);
    localparam int NCH   = envelope_crypto_pkg::NCH;
    localparam int NENT  = envelope_crypto_pkg::NENT;
    localparam int BLK_W = envelope_crypto_pkg::BLK_W;
    localparam int EQ_W  = envelope_crypto_pkg::EQ_W;
    localparam int CTL_W = envelope_crypto_pkg::CTL_W;
    localparam int ENT_W = envelope_crypto_pkg::ENT_W;
    localparam int TMR_W = envelope_crypto_pkg::TMR_W;
    localparam int TW    = $bits(envelope_crypto_pkg::tag_eq_t);

    function automatic logic header_detect(input envelope_crypto_pkg::eq_t eq);
        header_detect = eq.ctrl[0] && (eq.data[7:0] == envelope_crypto_pkg::HDR_CODE);
    endfunction

    function automatic logic [ENT_W-1:0] link_to_entity_map(
        input logic [envelope_crypto_pkg::LLID_W-1:0] llid);
        if (llid >= envelope_crypto_pkg::MCAST_BASE) begin
            link_to_entity_map = {1'b1, llid[envelope_crypto_pkg::MCAST_W-1:0]};
        end else begin
            link_to_entity_map = {1'b0,
                llid[envelope_crypto_pkg::UNIT_LSB +: envelope_crypto_pkg::UNIT_W]};
        end
    endfunction

    envelope_crypto_pkg::state_t  state_q;
    envelope_crypto_pkg::tag_eq_t cur_q;
    envelope_crypto_pkg::tag_eq_t fifo_data;
    logic                         fifo_valid;
    logic                         fifo_pop;

    // per-channel activation instance state
    logic [BLK_W-1:0] ctr_q  [NCH];
    logic [BLK_W-1:0] ks_q   [NCH];
    logic [NCH-1:0]   ksv_q;
    logic [NCH-1:0]   half_q;
    logic [NCH-1:0]   slot_q;

    // per-entity state and the shared tick counter
    logic [TMR_W-1:0] tmr_q [NENT];
    logic [NENT-1:0]  exp_q;
    logic [NENT-1:0]  pend_q;
    logic [NENT-1:0]  eslot_q;
    logic [envelope_crypto_pkg::TICK_W-1:0] tick_cnt_q;
    logic             tick;

    logic [envelope_crypto_pkg::CH_W-1:0] cur_ch;
    logic [ENT_W-1:0] cur_ent;
    logic             cur_hdr;
    logic             in_eval;
    logic             use_key;
    logic             ks_ok;
    logic             need_aes;
    logic             done;
    logic [EQ_W-1:0]  ks_sel;
    logic [EQ_W-1:0]  mask;
    logic [BLK_W-1:0] iv;

    crypto_fifo #(
        .WIDTH (TW),
        .DEPTH (envelope_crypto_pkg::FIFO_DEPTH)
    ) u_in_fifo (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_wr_valid (i_in_valid),
        .o_wr_ready (o_in_ready),
        .i_wr_data  (i_in_eq),
        .o_rd_valid (fifo_valid),
        .i_rd_ready (fifo_pop),
        .o_rd_data  (fifo_data)
    );

    // one quantum in flight; the output register gates the fifo drain
    assign fifo_pop = (state_q == envelope_crypto_pkg::ST_IDLE) && !o_out_valid;

    assign cur_ch   = cur_q.ch;
    assign cur_ent  = link_to_entity_map(cur_q.llid);
    assign cur_hdr  = header_detect(cur_q.eq);
    assign in_eval  = state_q == envelope_crypto_pkg::ST_EVAL;
    // expired entity: encrypted payload passes untouched and is flagged as a fault
    assign use_key  = !cur_hdr && cur_q.enc && !exp_q[cur_ent];
    assign ks_ok    = ksv_q[cur_ch];
    assign need_aes = in_eval && use_key && !ks_ok;
    assign done     = in_eval && !(use_key && !ks_ok);

    // first quantum of a pair takes the upper half; a lone last one leaves the lower unused
    assign ks_sel = half_q[cur_ch] ? ks_q[cur_ch][EQ_W-1:0]
                                   : ks_q[cur_ch][BLK_W-1:EQ_W];

    generate
        for (genvar b = 0; b < CTL_W; b++) begin : g_mask
            assign mask[8*b +: 8] = cur_q.eq.ctrl[b] ? 8'h00 : 8'hff;
        end
    endgenerate

    assign iv = {i_dir_up,
                 envelope_crypto_pkg::IV_CHN_W'(cur_ch),
                 i_mac_addr,
                 cur_q.eq.data[envelope_crypto_pkg::TIME_W-1:0],
                 {envelope_crypto_pkg::BIDX_W{1'b0}}};

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= envelope_crypto_pkg::ST_IDLE;
        end else begin
            case (state_q)
                envelope_crypto_pkg::ST_IDLE: begin
                    if (fifo_pop && fifo_valid) begin
                        state_q <= envelope_crypto_pkg::ST_EVAL;
                    end
                end
                envelope_crypto_pkg::ST_EVAL: begin
                    if (need_aes) begin
                        state_q <= envelope_crypto_pkg::ST_AES;
                    end else begin
                        state_q <= envelope_crypto_pkg::ST_IDLE;
                    end
                end
                envelope_crypto_pkg::ST_AES: begin
                    if (i_aes_ack) begin
                        state_q <= envelope_crypto_pkg::ST_EVAL;
                    end
                end
                default: state_q <= envelope_crypto_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cur_q <= '0;
        end else if (fifo_pop && fifo_valid) begin
            cur_q <= fifo_data;
        end
    end

    // cipher request holds until the core acknowledges
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_aes_req  <= 1'b0;
            o_aes_ctr  <= '0;
            o_aes_ent  <= '0;
            o_aes_slot <= 1'b0;
        end else if (need_aes) begin
            o_aes_req  <= 1'b1;
            o_aes_ctr  <= ctr_q[cur_ch];
            o_aes_ent  <= cur_ent;
            o_aes_slot <= slot_q[cur_ch];
        end else if (i_aes_ack) begin
            o_aes_req  <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_out_valid <= 1'b0;
            o_out_eq    <= '0;
            o_out_fault <= 1'b0;
            o_hdr_seen  <= 1'b0;
        end else begin
            o_hdr_seen <= done && cur_hdr;
            if (done) begin
                o_out_valid <= 1'b1;
                o_out_eq    <= cur_q;
                o_out_fault <= !cur_hdr && cur_q.enc && exp_q[cur_ent];
                if (use_key) begin
                    o_out_eq.eq.data <= cur_q.eq.data ^ (ks_sel & mask);
                end
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
        end
    end

    // one independent activation instance per channel, for either direction
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            logic hit;
            assign hit = cur_ch == envelope_crypto_pkg::CH_W'(c);

            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    ctr_q[c]  <= '0;
                    ksv_q[c]  <= 1'b0;
                    half_q[c] <= 1'b0;
                    slot_q[c] <= 1'b0;
                end else if (hit && in_eval && cur_hdr) begin
                    ctr_q[c]  <= iv;
                    ksv_q[c]  <= 1'b0;
                    half_q[c] <= 1'b0;
                    slot_q[c] <= eslot_q[cur_ent] ^ pend_q[cur_ent];
                end else if (hit && in_eval && use_key && ks_ok) begin
                    half_q[c] <= !half_q[c];
                    if (half_q[c]) begin
                        ksv_q[c] <= 1'b0;
                        ctr_q[c] <= ctr_q[c] + BLK_W'(1);
                    end
                end else if (hit && i_aes_ack &&
                             state_q == envelope_crypto_pkg::ST_AES) begin
                    ksv_q[c] <= 1'b1;
                end
            end

            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    ks_q[c] <= '0;
                end else if (hit && i_aes_ack &&
                             state_q == envelope_crypto_pkg::ST_AES) begin
                    ks_q[c] <= i_aes_block;
                end
            end
        end
    endgenerate

    // shared tick keeps the per-entity counters narrow
    assign tick = tick_cnt_q ==
                  envelope_crypto_pkg::TICK_W'(envelope_crypto_pkg::KEY_TICK_CYC - 1);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b || tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    generate
        for (genvar e = 0; e < NENT; e++) begin : g_ent
            logic sw;
            assign sw = in_eval && cur_hdr && pend_q[e] && cur_ent == ENT_W'(e);

            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    tmr_q[e] <= '0;
                    exp_q[e] <= 1'b0;
                end else if (i_key_load[e]) begin
                    tmr_q[e] <= i_key_interval;
                    exp_q[e] <= 1'b0;
                end else if (tick && tmr_q[e] != '0) begin
                    tmr_q[e] <= tmr_q[e] - 1'b1;
                    if (tmr_q[e] == TMR_W'(1)) begin
                        exp_q[e] <= 1'b1;
                    end
                end
            end

            // activation request waits for the next header; a new request beats the clear
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_b) begin
                    pend_q[e]  <= 1'b0;
                    eslot_q[e] <= 1'b0;
                end else begin
                    pend_q[e] <= i_key_activate[e] || (pend_q[e] && !sw);
                    if (sw) begin
                        eslot_q[e] <= !eslot_q[e];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_key_expired <= '0;
        end else begin
            o_key_expired <= exp_q;
        end
    end

endmodule // envelope_aes_ctr_crypto

`default_nettype wire

// *** sim/envelope_aes_ctr_crypto_assertions.sv ***
// port checks for the envelope crypto datapath
`timescale 1ns/1ns
`default_nettype none
module envelope_aes_ctr_crypto_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic o_out_valid,
    input wire logic i_out_ready,
    input wire envelope_crypto_pkg::tag_eq_t o_out_eq,
    input wire logic o_out_fault,
    input wire logic o_hdr_seen,
    input wire logic o_aes_req,
    input wire logic [127:0] o_aes_ctr,
    input wire logic [3:0] o_aes_ent,
    input wire logic o_aes_slot,
    input wire logic i_aes_ack,
    input wire logic [15:0] i_key_load,
    input wire logic [15:0] o_key_expired
);
    logic [15:0] load_q;
    logic [15:0] keep_q;
    // flags loaded in the last two cycles may still be clearing, so they are left out
    always_ff @(posedge i_core_clk) begin
        load_q <= i_rst_b ? i_key_load : '0;
        keep_q <= i_rst_b ? (o_key_expired & ~i_key_load & ~load_q) : '0;
    end
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_req_holds:
    assert property (o_aes_req && !i_aes_ack |=> o_aes_req && $stable(o_aes_ctr)
        && $stable(o_aes_ent) && $stable(o_aes_slot)) else $error("request moved");
    a_req_release:
    assert property (o_aes_req && i_aes_ack |=> !o_aes_req) else $error("request held");
    a_out_holds:
    assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_eq)
        && $stable(o_out_fault)) else $error("output moved");
    a_hdr_shape:
    assert property (o_hdr_seen |-> o_out_valid && o_out_eq.eq.ctrl[0] && !o_out_fault
        && o_out_eq.eq.data[7:0] == 8'h5c) else $error("header pulse on non-header");
    a_hdr_gap:
    assert property (o_hdr_seen |=> !o_hdr_seen [*2]) else $error("header pulse too long");
    a_expired_sticky:
    assert property ((o_key_expired & keep_q) == keep_q) else $error("expiry flag dropped");
    a_load_clears:
    assert property (load_q != '0 |=> (o_key_expired & $past(load_q)) == '0)
        else $error("load left expiry flag set");
    a_fault_enc:
    assert property (o_out_valid && o_out_fault |-> o_out_eq.enc) else $error("stray fault");
endmodule // envelope_aes_ctr_crypto_assertions
bind envelope_aes_ctr_crypto envelope_aes_ctr_crypto_assertions u_checks (
    .i_core_clk, .i_rst_b, .o_out_valid, .i_out_ready, .o_out_eq, .o_out_fault, .o_hdr_seen,
    .o_aes_req, .o_aes_ctr, .o_aes_ent, .o_aes_slot, .i_aes_ack, .i_key_load, .o_key_expired);
`default_nettype wire

// *** sim/aes_block_responder.sv ***
// stand-in for the forward cipher core, fast or slow
`timescale 1ns/1ns
`default_nettype none
module aes_block_responder (
    input  wire logic         i_core_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_slow,
    input  wire logic         i_req,
    input  wire logic [127:0] i_ctr,
    input  wire logic [3:0]   i_ent,
    input  wire logic         i_slot,
    output logic              o_ack,
    output logic [127:0]      o_block
);
    logic [2:0] wait_q;
    // between answers the block bus walks, so a stale block never looks valid
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_ack <= 1'b0;
            wait_q <= 3'd0;
            o_block <= '0;
        end else if (!o_ack && i_req && wait_q == 3'd0) begin
            o_ack <= 1'b1;
            o_block <= {i_ctr[63:0], i_ctr[127:64]} ^ {16{i_ent, 3'b101, i_slot}};
        end else begin
            o_ack <= 1'b0;
            wait_q <= (i_req && !o_ack) ? wait_q - 3'd1 : (i_slow ? 3'd6 : 3'd0);
            o_block <= {o_block[126:0], ~o_block[127]};
        end
    end
endmodule // aes_block_responder
`default_nettype wire

// *** sim/envelope_aes_ctr_crypto_tb.sv ***
// self-checking bench for the envelope crypto datapath
`timescale 1ns/1ns
`default_nettype none
module envelope_aes_ctr_crypto_tb;
    typedef envelope_crypto_pkg::tag_eq_t q_t;
    typedef struct packed {q_t t; logic f;} exp_t;
    logic clk = 1'b0, rst_b = 1'b0, dir = 1'b0, vld = 1'b0, rdy = 1'b1, slow = 1'b0;
    logic in_rdy, out_vld, fault, hdr_seen, req, slot, ack;
    logic [127:0] ctr, blk, c_m[4];
    logic [47:0] mac = 48'h0a1b_2c3d_4e5f;
    logic [15:0] load = '0, ival = '0, act = '0, expd;
    logic [3:0] ent, e_m[4];
    logic h_m[4], s_m[4], k_m[16] = '{default: 0}, p_m[16] = '{default: 0}, d_m[16] = '{default: 0};
    q_t in_q = '0, out_q;
    exp_t x_q[$], got;
    int errors = 0, samples_checked = 0, hdrs = 0;
    always #50 clk = ~clk;
    envelope_aes_ctr_crypto u_envelope_aes_ctr_crypto (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_dir_up(dir), .i_mac_addr(mac), .i_in_valid(vld), .o_in_ready(in_rdy), .i_in_eq(in_q),
        .o_out_valid(out_vld), .i_out_ready(rdy), .o_out_eq(out_q), .o_out_fault(fault),
        .o_hdr_seen(hdr_seen), .o_aes_req(req), .o_aes_ctr(ctr), .o_aes_ent(ent),
        .o_aes_slot(slot), .i_aes_ack(ack), .i_aes_block(blk), .i_key_load(load),
        .i_key_interval(ival), .i_key_activate(act), .o_key_expired(expd));
    aes_block_responder u_aes_block_responder (.i_core_clk(clk), .i_rst_b(rst_b), .i_slow(slow),
        .i_req(req), .i_ctr(ctr), .i_ent(ent), .i_slot(slot), .o_ack(ack), .o_block(blk));
    function automatic logic [3:0] map(logic [15:0] l);
        return l >= 16'h7f00 ? {1'b1, l[2:0]} : {1'b0, l[5:3]};
    endfunction
    task automatic check(logic ok, string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic model(q_t t);
        exp_t x;
        logic [127:0] b;
        logic [63:0] k;
        logic [1:0] c;
        c = t.ch;
        x = {t, 1'b0};
        if (t.eq.ctrl[0] && t.eq.data[7:0] == 8'h5c) begin
            e_m[c] = map(t.llid);
            if (p_m[e_m[c]]) k_m[e_m[c]] = ~k_m[e_m[c]];
            p_m[e_m[c]] = 1'b0;
            s_m[c] = k_m[e_m[c]];
            c_m[c] = {dir, 5'h00, c, mac, t.eq.data[47:0], 24'h0};
            h_m[c] = 1'b0;
        end else if (!t.enc) x.f = 1'b0;
        else if (d_m[e_m[c]]) x.f = 1'b1;
        else begin
            b = {c_m[c][63:0], c_m[c][127:64]} ^ {16{e_m[c], 3'b101, s_m[c]}};
            k = h_m[c] ? b[63:0] : b[127:64];
            for (int i = 0; i < 8; i++) if (t.eq.ctrl[i]) k[8*i+:8] = 8'h00;
            x.t.eq.data ^= k;
            if (h_m[c]) c_m[c] += 128'h1;
            h_m[c] = ~h_m[c];
        end
        x_q.push_back(x);
    endtask
    task automatic send(logic [63:0] d, logic [7:0] cc, logic [1:0] c, logic [15:0] l,
                        logic e = 1'b1);
        int n = 0;
        in_q <= {d, cc, c, l, e};
        vld <= 1'b1;
        do @(posedge clk); while (in_rdy !== 1'b1 && ++n < 500);
        check(n < 500, "input refused");
        model(in_q);
    endtask
    task automatic hdr(logic [1:0] c, logic [15:0] l, logic [31:0] tm);
        send({24'h0, tm, 8'h5c}, 8'h01, c, l);
    endtask
    task automatic drain();
        int n = 0;
        vld <= 1'b0;
        while (x_q.size() != 0 && n++ < 3000) @(posedge clk);
        check(x_q.size() == 0, "output stalled");
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rst_b && hdr_seen === 1'b1) hdrs++;
        if (rst_b && out_vld === 1'b1 && rdy === 1'b1) begin
            got = x_q.size() != 0 ? x_q.pop_front() : 'x;
            samples_checked++;
            if ({out_q, fault} !== got) begin
                errors++;
                $display("[FAIL] %0t got %h/%b want %h", $time, out_q, fault, got);
            end
        end
    end
    task automatic t_stream();
        hdrs = 0;
        hdr(2'd1, 16'h0008, 32'h1000);
        for (int i = 0; i < 5; i++) send(64'h1111_2222_3333_4400 + i, 8'h00, 2'd1, 16'h0008);
        send(64'h8877_6655_4433_2211, 8'h81, 2'd1, 16'h0008);
        send(64'h0102_0304_0506_075c, 8'h02, 2'd1, 16'h0008);
        hdr(2'd1, 16'h0008, 32'h1001);
        send(64'hffff_0000_ffff_0000, 8'h00, 2'd1, 16'h0008);
        drain();
        check(hdrs == 2, "header pulse count");
    endtask
    task automatic t_channels();
        logic [15:0] l[4] = '{16'h0008, 16'h000d, 16'h7f02, 16'h7f05};
        dir <= 1'b1;
        slow <= 1'b1;
        for (int c = 0; c < 4; c++) hdr(c[1:0], l[c], 32'h2000 + c);
        for (int i = 0; i < 12; i++) send(64'h0123_4567 + i, 8'h00, i[1:0], l[i%4]);
        drain();
        dir <= 1'b0;
        slow <= 1'b0;
    endtask
    task automatic t_switch();
        hdr(2'd0, 16'h0008, 32'h3000);
        send(64'h00aa_00bb_00cc_00dd, 8'h00, 2'd0, 16'h0008);
        drain();
        act <= 16'h0002;
        p_m[1] = 1'b1;
        @(posedge clk);
        act <= 16'h0000;
        send(64'h1234_0000_0000_4321, 8'h00, 2'd0, 16'h0008);
        hdr(2'd0, 16'h0008, 32'h3001);
        send(64'h1234_0000_0000_4321, 8'h00, 2'd0, 16'h0008);
        drain();
    endtask
    task automatic t_expiry();
        ival <= 16'h0002;
        load <= 16'h0004;
        @(posedge clk);
        load <= 16'h0000;
        repeat (40) @(posedge clk);
        check(expd === 16'h0004, "expiry flag");
        d_m[2] = 1'b1;
        hdr(2'd2, 16'h0010, 32'h4000);
        send(64'h0f0f_0f0f_0f0f_0f0f, 8'h00, 2'd2, 16'h0010);
        send(64'h0f0f_0f0f_0f0f_0f0f, 8'h00, 2'd2, 16'h0010, 1'b0);
        drain();
        ival <= 16'h0000;
        load <= 16'h0004;
        @(posedge clk);
        load <= 16'h0000;
        repeat (3) @(posedge clk);
        check(expd === 16'h0000, "expiry flag kept");
        d_m[2] = 1'b0;
    endtask
    task automatic t_fill();
        int n;
        rdy <= 1'b0;
        slow <= 1'b1;
        hdr(2'd3, 16'h0018, 32'h5000);
        for (n = 0; n < 24; n++) begin
            in_q <= {64'h5a5a_0000_0000_0000 + n, 8'h00, 2'd3, 16'h0018, 1'b1};
            @(posedge clk);
            if (in_rdy !== 1'b1) break;
            model(in_q);
        end
        check(n == envelope_crypto_pkg::FIFO_DEPTH, "fifo depth wrong");
        rdy <= 1'b1;
        drain();
        check(in_rdy === 1'b1, "fifo not empty");
        slow <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        check({in_rdy, out_vld, hdr_seen, req, expd} === '0, "busy in reset");
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_stream();
        t_channels();
        t_switch();
        t_expiry();
        t_fill();
        tally_and_finish();
    end
    initial begin
        #(100 * 50000);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule // envelope_aes_ctr_crypto_tb
`default_nettype wire
